// *** include/ref_uv_defines.svh ***
`ifndef REF_UV_DEFINES_SVH
`define REF_UV_DEFINES_SVH

// Clock and one-second timebase
`define CLOCK_PERIOD_NS 100
`define SECOND_NS       1000000000
`define TICK_CYCLES     (`SECOND_NS / `CLOCK_PERIOD_NS)

// Reference loss threshold and emergency values, analog in uA, pulse in Hz
`define LOSS_THRESHOLD_UA 16'h0BB8
`define EMERG_ANALOG_UA   16'h0FA0
`define EMERG_PULSE_HZ    16'h0000

// Undervoltage threshold is nominal * NUM >> SHIFT
`define UV_THR_NUM   16'h000F
`define UV_THR_SHIFT 4

// Reset values of the configuration
`define REF_MON_EN_RST    1'b0
`define LOSS_RESP_RST     2'h1
`define PHASE_MON_RST     1'b1
`define UV_MODE_RST       3'h1
`define ALLOWED_UV_S_RST  12'h002
`define MAX_UV_S_RST      12'h01E
`define NOMINAL_V_RST     16'h0190

`endif

// *** include/ref_uv_pkg.sv ***
`default_nettype none
package ref_uv_pkg;

  typedef enum logic [1:0] {
    RESP_TRIP  = 2'h1,
    RESP_HOLD  = 2'h2,
    RESP_EMERG = 2'h3
  } lossResp_t;

  typedef enum logic [2:0] {
    UV_DELAYED_FAULT = 3'h1,
    UV_ALARM_FAULT   = 3'h2,
    UV_ALARM_ONLY    = 3'h3,
    UV_RIDE_THROUGH  = 3'h4,
    UV_FAST_STOP     = 3'h5
  } uvMode_t;

  typedef enum logic [2:0] {
    ST_NORMAL    = 3'h0,
    ST_BLOCKED   = 3'h1,
    ST_RIDE      = 3'h2,
    ST_FAST_STOP = 3'h3,
    ST_FAULT     = 3'h4
  } uvState_t;

  typedef struct packed {
    logic        enable;
    lossResp_t   resp;
    logic [15:0] emergency;
  } refCfg_t;

  typedef struct packed {
    uvMode_t     mode;
    logic        phaseMon;
    logic [11:0] allowedUvTime;
    logic [11:0] maxUvTime;
    logic [15:0] nominalSupply;
  } uvCfg_t;

  typedef struct packed {
    logic [15:0] lastValid;
    logic [15:0] refOut;
    logic        failed;
    logic        alarm;
    logic        fault;
  } chanState_t;

  typedef struct packed {
    refCfg_t [3:0] refCfg;
    uvCfg_t        uvCfg;
    logic          phaseMeta;
    logic          phaseLost;
    logic          uvFlag;
    uvState_t      uvState;
    logic [23:0]   tickCount;
    logic [11:0]   secCount;
    logic          uvAlarm;
    logic          restartReq;
    logic          cancelStart;
    logic          runIndication;
    logic          phaseFault;
    logic          outputBlock;
    logic          fastStopReq;
  } supState_t;

endpackage : ref_uv_pkg
`default_nettype wire

// *** verilog/ref_channel.sv ***
`include "ref_uv_defines.svh"
`default_nettype none
module ref_channel #(
  parameter bit IS_PULSE = 1'b0
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire ref_uv_pkg::refCfg_t cfg,
  input  wire logic [15:0]         measured,
  input  wire logic [15:0]         minFreq,
  input  wire logic                faultReset,
  output logic [15:0]              refOut,
  output logic                     failed,
  output logic                     alarm,
  output logic                     fault
);

  ref_uv_pkg::chanState_t s;
  ref_uv_pkg::chanState_t n;
  logic                   lost;

  function automatic logic belowLimit(input logic [15:0] value,
                                      input logic [15:0] freqMin);
    logic [16:0] doubled;
    doubled = {value, 1'b0};
    if (IS_PULSE) begin
      belowLimit = doubled < {1'b0, freqMin};
    end else begin
      belowLimit = value < `LOSS_THRESHOLD_UA;
    end
  endfunction : belowLimit

  always_comb begin
    n = s;
    lost = cfg.enable && belowLimit(measured, minFreq);
    n.failed = lost;
    n.alarm = 1'b0;
    if (!lost) begin
      n.lastValid = measured;
      n.refOut = measured;
      if (faultReset) begin
        n.fault = 1'b0;
      end
    end else begin
      unique case (cfg.resp)
        ref_uv_pkg::RESP_HOLD: begin
          n.alarm = 1'b1;
          n.refOut = s.lastValid;
        end
        ref_uv_pkg::RESP_EMERG: begin
          n.alarm = 1'b1;
          n.refOut = cfg.emergency;
        end
        default: begin
          // Code 0 is illegal and treated as trip, the safe choice
          n.fault = 1'b1;
          n.refOut = s.lastValid;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign refOut = s.refOut;
  assign failed = s.failed;
  assign alarm  = s.alarm;
  assign fault  = s.fault;

endmodule : ref_channel
`default_nettype wire

// *** verilog/ref_uv_supervisor.sv ***
// What this block does
// - Analog loop below 3 mA means failure
// - Pulse below half minimum means failure
// - Per-input monitor enable, default off
// - Response 1 trips, naming failed input
// - Response 2 holds last value, alarms
// - Response 3 substitutes emergency value, alarms
// - Emergency defaults 4 mA and 0 kHz
// - Substitutes drive the reference distributor input
// - Phase loss while running trips drive
// - DC link below derived threshold flags undervoltage
// - Allowed time bounds restart, run stays
// - Ride-through and fast-stop limited by maximum
// - Delayed fault blocks, restarts or faults
// - Alarm-then-fault blocks, alarms, restarts or faults
// - Alarm-only blocks, alarms, always restarts
// - Ride-through recovers in time else faults
// - Fast stop ramps down holding alarm
// - Standstill clears alarm, cancels start command
`include "ref_uv_defines.svh"
`default_nettype none
module ref_uv_supervisor #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int CHANNELS    = 4
) (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          cfgLoad,
  input  wire ref_uv_pkg::refCfg_t [3:0]     refCfgIn,
  input  wire ref_uv_pkg::uvCfg_t            uvCfgIn,
  input  wire logic [15:0]                   analogRefInputB,
  input  wire logic [15:0]                   analogRefInputC,
  input  wire logic [15:0]                   analogRefInputD,
  input  wire logic [15:0]                   pulseRefInput,
  input  wire logic [15:0]                   lowFreqPulseRefInput,
  input  wire logic                          lowFreqPulseSel,
  input  wire logic [15:0]                   pulseMinFreq,
  input  wire logic [15:0]                   dcLinkVoltage,
  input  wire logic                          phaseLostPin,
  input  wire logic                          running,
  input  wire logic                          standstill,
  input  wire logic                          faultReset,
  output logic [3:0][15:0]                   distribRef,
  output logic [3:0]                         refFailed,
  output logic [3:0]                         refAlarm,
  output logic [3:0]                         refFault,
  output logic                               singlePhaseLossFault,
  output logic                               undervoltage,
  output logic                               uvAlarm,
  output logic                               uvFault,
  output logic                               outputBlock,
  output logic                               restartReq,
  output logic                               fastStopReq,
  output logic                               cancelStart,
  output logic                               runIndication,
  output logic                               faultShutdown,
  output logic [11:0]                        uvSeconds
);

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  ref_uv_pkg::supState_t s;
  ref_uv_pkg::supState_t n;
  logic [3:0][15:0]      measured;
  logic                  uvNow;
  logic                  tick;
  logic                  allowedOver;
  logic                  maxOver;

  // Saturating second count compared against a limit in seconds
  function automatic logic limitReached(input logic [11:0] count,
                                        input logic [11:0] limit);
    limitReached = count >= limit;
  endfunction : limitReached

  function automatic logic [15:0] uvThreshold(input logic [15:0] nominal);
    logic [19:0] scaled;
    scaled = 20'(nominal) * 20'(`UV_THR_NUM);
    uvThreshold = 16'(scaled >> `UV_THR_SHIFT);
  endfunction : uvThreshold

  // Constant, so the asynchronous reset branch loads no logic output
  function automatic ref_uv_pkg::supState_t resetValue();
    resetValue = '0;
    for (int i = 0; i < 4; i++) begin
      resetValue.refCfg[i].enable = `REF_MON_EN_RST;
      resetValue.refCfg[i].resp = ref_uv_pkg::lossResp_t'(`LOSS_RESP_RST);
      resetValue.refCfg[i].emergency = `EMERG_ANALOG_UA;
    end
    resetValue.refCfg[3].emergency = `EMERG_PULSE_HZ;
    resetValue.uvCfg.mode = ref_uv_pkg::uvMode_t'(`UV_MODE_RST);
    resetValue.uvCfg.phaseMon = `PHASE_MON_RST;
    resetValue.uvCfg.allowedUvTime = `ALLOWED_UV_S_RST;
    resetValue.uvCfg.maxUvTime = `MAX_UV_S_RST;
    resetValue.uvCfg.nominalSupply = `NOMINAL_V_RST;
    resetValue.uvState = ref_uv_pkg::ST_NORMAL;
  endfunction : resetValue
  localparam ref_uv_pkg::supState_t RST_VAL = resetValue();

  // Pulse channel takes whichever pulse source is selected
  always_comb begin
    measured[0] = analogRefInputB;
    measured[1] = analogRefInputC;
    measured[2] = analogRefInputD;
    measured[3] = lowFreqPulseSel ? lowFreqPulseRefInput : pulseRefInput;
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : gChan
    ref_channel #(
      .IS_PULSE (g == 3)
    ) uChan (
      .clock      (clock),
      .resetn     (resetn),
      .cfg        (s.refCfg[g]),
      .measured   (measured[g]),
      .minFreq    (pulseMinFreq),
      .faultReset (faultReset),
      .refOut     (distribRef[g]),
      .failed     (refFailed[g]),
      .alarm      (refAlarm[g]),
      .fault      (refFault[g])
    );
  end

  assign uvNow = dcLinkVoltage < uvThreshold(s.uvCfg.nominalSupply);

  always_comb begin
    n = s;
    n.restartReq = 1'b0;
    n.cancelStart = 1'b0;
    if (cfgLoad) begin
      n.refCfg = refCfgIn;
      n.uvCfg = uvCfgIn;
    end

    // Pin is asynchronous, two stages before use
    n.phaseMeta = phaseLostPin;
    n.phaseLost = s.phaseMeta;
    n.uvFlag = uvNow;

    // Set wins over a reset arriving in the same cycle
    if (s.uvCfg.phaseMon && running && s.phaseLost) begin
      n.phaseFault = 1'b1;
    end else if (faultReset) begin
      n.phaseFault = 1'b0;
    end

    // One-second timebase runs only while an undervoltage is handled
    tick = s.tickCount == TICK_LAST;
    allowedOver = limitReached(s.secCount, s.uvCfg.allowedUvTime);
    maxOver = limitReached(s.secCount, s.uvCfg.maxUvTime);
    if (s.uvState == ref_uv_pkg::ST_NORMAL || s.uvState == ref_uv_pkg::ST_FAULT) begin
      n.tickCount = '0;
      n.secCount = '0;
    end else if (tick) begin
      n.tickCount = '0;
      if (s.secCount != 12'hFFF) begin
        n.secCount = s.secCount + 12'h001;
      end
    end else begin
      n.tickCount = s.tickCount + 24'h000001;
    end

    unique case (s.uvState)
      ref_uv_pkg::ST_NORMAL: begin
        n.uvAlarm = 1'b0;
        if (s.uvFlag && running) begin
          n.tickCount = '0;
          n.secCount = '0;
          unique case (s.uvCfg.mode)
            ref_uv_pkg::UV_RIDE_THROUGH: begin
              n.uvState = ref_uv_pkg::ST_RIDE;
              n.uvAlarm = 1'b1;
            end
            ref_uv_pkg::UV_FAST_STOP: begin
              n.uvState = ref_uv_pkg::ST_FAST_STOP;
              n.uvAlarm = 1'b1;
            end
            ref_uv_pkg::UV_ALARM_FAULT,
            ref_uv_pkg::UV_ALARM_ONLY: begin
              n.uvState = ref_uv_pkg::ST_BLOCKED;
              n.uvAlarm = 1'b1;
            end
            default: begin
              // Unknown modes fall back to the coast-and-wait behaviour
              n.uvState = ref_uv_pkg::ST_BLOCKED;
            end
          endcase
        end
      end
      ref_uv_pkg::ST_BLOCKED: begin
        if (!s.uvFlag) begin
          n.uvState = ref_uv_pkg::ST_NORMAL;
          n.restartReq = 1'b1;
          n.uvAlarm = 1'b0;
        end else if (s.uvCfg.mode != ref_uv_pkg::UV_ALARM_ONLY && allowedOver) begin
          n.uvState = ref_uv_pkg::ST_FAULT;
          n.uvAlarm = 1'b0;
        end
      end
      ref_uv_pkg::ST_RIDE: begin
        if (!s.uvFlag) begin
          n.uvState = ref_uv_pkg::ST_NORMAL;
          n.uvAlarm = 1'b0;
        end else if (maxOver) begin
          n.uvState = ref_uv_pkg::ST_FAULT;
          n.uvAlarm = 1'b0;
        end
      end
      ref_uv_pkg::ST_FAST_STOP: begin
        // Stop runs to the end even if voltage recovers meanwhile
        if (standstill) begin
          n.uvState = ref_uv_pkg::ST_NORMAL;
          n.uvAlarm = 1'b0;
          n.cancelStart = 1'b1;
        end else if (maxOver) begin
          n.uvState = ref_uv_pkg::ST_FAULT;
          n.uvAlarm = 1'b0;
        end else begin
          n.uvAlarm = 1'b1;
        end
      end
      ref_uv_pkg::ST_FAULT: begin
        n.uvAlarm = 1'b0;
        // Reset refused while the cause remains
        if (faultReset && !s.uvFlag) begin
          n.uvState = ref_uv_pkg::ST_NORMAL;
        end
      end
      default: begin
        n.uvState = ref_uv_pkg::ST_FAULT;
      end
    endcase

    n.outputBlock = n.uvState == ref_uv_pkg::ST_BLOCKED
                 || n.uvState == ref_uv_pkg::ST_FAULT;
    n.fastStopReq = n.uvState == ref_uv_pkg::ST_FAST_STOP;
    unique case (n.uvState)
      ref_uv_pkg::ST_NORMAL: begin
        n.runIndication = running;
      end
      ref_uv_pkg::ST_BLOCKED: begin
        // Run message only while the seconds count is below the allowed time
        n.runIndication = !limitReached(n.secCount, s.uvCfg.allowedUvTime);
      end
      ref_uv_pkg::ST_RIDE,
      ref_uv_pkg::ST_FAST_STOP: begin
        n.runIndication = 1'b1;
      end
      default: begin
        n.runIndication = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= RST_VAL;
    end else begin
      s <= n;
    end
  end

  assign singlePhaseLossFault = s.phaseFault;
  assign undervoltage = s.uvFlag;
  assign uvAlarm = s.uvAlarm;
  assign uvFault = s.uvState == ref_uv_pkg::ST_FAULT;
  assign outputBlock = s.outputBlock;
  assign restartReq = s.restartReq;
  assign fastStopReq = s.fastStopReq;
  assign cancelStart = s.cancelStart;
  assign runIndication = s.runIndication;
  assign uvSeconds = s.secCount;
  assign faultShutdown = s.phaseFault || (|refFault)
                      || s.uvState == ref_uv_pkg::ST_FAULT;

endmodule : ref_uv_supervisor
`default_nettype wire

// *** bench/ref_uv_far_side.sv ***
`default_nettype none
module ref_uv_far_side (
  input  wire logic [3:0] lossMask,
  input  wire logic       mainsSag,
  input  wire logic       phaseDrop,
  output logic [15:0]     loopB,
  output logic [15:0]     loopC,
  output logic [15:0]     loopD,
  output logic [15:0]     pulseHz,
  output logic [15:0]     lowPulseHz,
  output logic [15:0]     dcLink,
  output logic            phaseLost
);
  // Input B, the pulse input and the DC link sit on the loss boundaries to catch off-by-one compares
  assign loopB      = lossMask[0] ? 16'h0BB7 : 16'h0BB8;
  assign loopC      = lossMask[1] ? 16'h0BB7 : 16'h2EE0;
  assign loopD      = lossMask[2] ? 16'h0000 : 16'h4E20;
  assign pulseHz    = lossMask[3] ? 16'h01F3 : 16'h01F4;
  assign lowPulseHz = 16'h0320;
  assign dcLink     = mainsSag ? 16'h0176 : 16'h0177;
  assign phaseLost  = phaseDrop;
endmodule : ref_uv_far_side
`default_nettype wire

// *** bench/ref_uv_supervisor_assertions.sv ***
`default_nettype none
module ref_uv_supervisor_checker (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        faultReset,
  input wire logic        phaseLostPin,
  input wire logic        running,
  input wire logic [15:0] dcLinkVoltage,
  input wire logic [3:0]  refFailed,
  input wire logic [3:0]  refAlarm,
  input wire logic [3:0]  refFault,
  input wire logic        singlePhaseLossFault,
  input wire logic        undervoltage,
  input wire logic        uvAlarm,
  input wire logic        uvFault,
  input wire logic        outputBlock,
  input wire logic        restartReq,
  input wire logic        fastStopReq,
  input wire logic        runIndication
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Threshold assumes the nominal 400 V is never reloaded
  a_uv_threshold: assert property (undervoltage == $past(dcLinkVoltage < 16'h0177))
    else $error("undervoltage flag off threshold");
  a_phase_trip: assert property ((phaseLostPin && running) [*3] |=> singlePhaseLossFault)
    else $error("phase loss not tripped");
  a_ref_sticky: assert property (!faultReset |=> (refFault & $past(refFault)) == $past(refFault))
    else $error("reference fault dropped");
  a_alarm_loss: assert property ((refAlarm & ~refFailed) == 4'h0)
    else $error("reference alarm without loss");
  a_uv_entry: assert property ($rose(undervoltage) && running && !uvFault && !outputBlock
    && !uvAlarm |=> uvAlarm || outputBlock)
    else $error("undervoltage not acted on");
  a_restart_cause: assert property (restartReq |-> !$past(undervoltage) && $past(outputBlock))
    else $error("restart without recovery");
  a_fault_block: assert property (uvFault |-> outputBlock && !runIndication)
    else $error("fault not blocking");
  a_fast_alarm: assert property (fastStopReq |-> uvAlarm)
    else $error("fast stop without alarm");
endmodule : ref_uv_supervisor_checker

bind ref_uv_supervisor ref_uv_supervisor_checker chk (
  .clock(clock), .resetn(resetn), .faultReset(faultReset), .phaseLostPin(phaseLostPin),
  .running(running), .dcLinkVoltage(dcLinkVoltage), .refFailed(refFailed),
  .refAlarm(refAlarm), .refFault(refFault), .singlePhaseLossFault(singlePhaseLossFault),
  .undervoltage(undervoltage), .uvAlarm(uvAlarm), .uvFault(uvFault),
  .outputBlock(outputBlock), .restartReq(restartReq), .fastStopReq(fastStopReq),
  .runIndication(runIndication)
);
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clock = 1'b0;
  logic                      resetn = 1'b0;
  logic                      cfgLoad = 1'b0;
  ref_uv_pkg::refCfg_t [3:0] refCfgIn = '{'{1'b1, ref_uv_pkg::RESP_EMERG, 16'h0000},
    '{1'b1, ref_uv_pkg::RESP_TRIP, 16'h0000}, '{1'b1, ref_uv_pkg::RESP_EMERG, 16'h0FA0},
    '{1'b1, ref_uv_pkg::RESP_HOLD, 16'h0000}};
  ref_uv_pkg::uvCfg_t        uvCfgIn = '0;
  logic [3:0]                lossMask = 4'hF;
  logic                      mainsSag = 1'b0;
  logic                      phaseDrop = 1'b0;
  logic                      lowFreqPulseSel = 1'b0;
  logic                      running = 1'b0;
  logic                      standstill = 1'b0;
  logic                      faultReset = 1'b0;
  logic [15:0]               loopB, loopC, loopD, pulseHz, lowPulseHz, dcLink;
  logic                      phaseLost, singlePhaseLossFault, undervoltage, uvAlarm, uvFault;
  logic                      outputBlock, restartReq, fastStopReq, cancelStart;
  logic                      runIndication, faultShutdown;
  logic [3:0][15:0]          distribRef;
  logic [3:0]                refFailed, refAlarm, refFault;
  logic [11:0]               uvSeconds;
  int                        num_errors = 0;
  int                        n_checks = 0;

  always #50 clock = ~clock;

  ref_uv_far_side far (.lossMask(lossMask), .mainsSag(mainsSag), .phaseDrop(phaseDrop),
    .loopB(loopB), .loopC(loopC), .loopD(loopD), .pulseHz(pulseHz),
    .lowPulseHz(lowPulseHz), .dcLink(dcLink), .phaseLost(phaseLost));

  // Short second keeps the time limits within a few tens of cycles
  ref_uv_supervisor #(.TICK_CYCLES(10), .CHANNELS(4)) dut (.clock(clock), .resetn(resetn),
    .cfgLoad(cfgLoad), .refCfgIn(refCfgIn), .uvCfgIn(uvCfgIn), .analogRefInputB(loopB),
    .analogRefInputC(loopC), .analogRefInputD(loopD), .pulseRefInput(pulseHz),
    .lowFreqPulseRefInput(lowPulseHz), .lowFreqPulseSel(lowFreqPulseSel),
    .pulseMinFreq(16'h03E8), .dcLinkVoltage(dcLink), .phaseLostPin(phaseLost),
    .running(running), .standstill(standstill), .faultReset(faultReset),
    .distribRef(distribRef), .refFailed(refFailed), .refAlarm(refAlarm),
    .refFault(refFault), .singlePhaseLossFault(singlePhaseLossFault),
    .undervoltage(undervoltage), .uvAlarm(uvAlarm), .uvFault(uvFault),
    .outputBlock(outputBlock), .restartReq(restartReq), .fastStopReq(fastStopReq),
    .cancelStart(cancelStart), .runIndication(runIndication),
    .faultShutdown(faultShutdown), .uvSeconds(uvSeconds));

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask : w

  // Waits out the pin synchroniser first, since a standing cause beats the reset
  task automatic clr();
    w(3);
    @(posedge clock);
    faultReset <= 1'b1;
    @(posedge clock);
    faultReset <= 1'b0;
    w(2);
  endtask : clr

  task automatic cfg(input ref_uv_pkg::uvMode_t m);
    @(posedge clock);
    cfgLoad <= 1'b1;
    uvCfgIn <= '{m, 1'b1, 12'h002, 12'h003, 16'h0190};
    @(posedge clock);
    cfgLoad <= 1'b0;
  endtask : cfg

  task automatic t_defaults();
    w(2);
    chk("refFailed", 16'h0000, 16'(refFailed));
    chk("liveRef", 16'h0BB7, distribRef[0]);
  endtask : t_defaults

  task automatic t_ref();
    @(posedge clock);
    lossMask <= 4'h0;
    cfg(ref_uv_pkg::UV_DELAYED_FAULT);
    w(2);
    chk("refFailed", 16'h0000, 16'(refFailed));
    @(posedge clock);
    lossMask <= 4'hF;
    w(2);
    chk("refFailed", 16'h000F, 16'(refFailed));
    chk("refAlarm", 16'h000B, 16'(refAlarm));
    chk("refFault", 16'h0004, 16'(refFault));
    chk("faultShutdown", 16'h0001, 16'(faultShutdown));
    chk("holdRef", 16'h0BB8, distribRef[0]);
    chk("emergRef", 16'h0FA0, distribRef[1]);
    chk("emergPulse", 16'h0000, distribRef[3]);
    @(posedge clock);
    lossMask <= 4'h0;
    lowFreqPulseSel <= 1'b1;
    w(2);
    chk("refAlarm", 16'h0000, 16'(refAlarm));
    chk("liveRef", 16'h2EE0, distribRef[1]);
    chk("lowPulseRef", 16'h0320, distribRef[3]);
    chk("refFault", 16'h0004, 16'(refFault));
    clr();
    chk("refFault", 16'h0000, 16'(refFault));
  endtask : t_ref

  task automatic t_phase();
    @(posedge clock);
    phaseDrop <= 1'b1;
    w(3);
    chk("phaseFault", 16'h0000, 16'(singlePhaseLossFault));
    w(1);
    chk("phaseFault", 16'h0001, 16'(singlePhaseLossFault));
    @(posedge clock);
    phaseDrop <= 1'b0;
    clr();
    chk("phaseFault", 16'h0000, 16'(singlePhaseLossFault));
  endtask : t_phase

  task automatic t_uvEntry();
    for (int i = 1; i < 6; i++) begin
      cfg(ref_uv_pkg::uvMode_t'(i));
      @(posedge clock);
      mainsSag <= 1'b1;
      w(3);
      chk("uvFlag", 16'h0001, 16'(undervoltage));
      chk("uvAlarm", 16'(i != 1), 16'(uvAlarm));
      chk("outputBlock", 16'(i < 4), 16'(outputBlock));
      chk("fastStopReq", 16'(i == 5), 16'(fastStopReq));
      chk("runIndication", 16'h0001, 16'(runIndication));
      @(posedge clock);
      if (i == 5) standstill <= 1'b1;
      else mainsSag <= 1'b0;
      w(i == 5 ? 2 : 3);
      chk("restartReq", 16'(i < 4), 16'(restartReq));
      chk("cancelStart", 16'(i == 5), 16'(cancelStart));
      chk("uvAlarm", 16'h0000, 16'(uvAlarm));
      @(posedge clock);
      mainsSag <= 1'b0;
      w(4);
      @(posedge clock);
      standstill <= 1'b0;
    end
  endtask : t_uvEntry

  task automatic t_uvLimit();
    int c;
    for (int i = 2; i < 6; i++) begin
      cfg(ref_uv_pkg::uvMode_t'(i));
      @(posedge clock);
      mainsSag <= 1'b1;
      c = 0;
      while (uvFault !== 1'b1 && c < 60) begin
        w(1);
        c++;
      end
      chk("uvFault", 16'(i != 3), 16'(uvFault));
      chk("uvLate", 16'h0001, 16'(c > (i == 2 ? 19 : 29)));
      chk("runIndication", 16'h0000, 16'(runIndication));
      chk("uvSeconds", 16'(i == 2 ? 2 : (i == 3 ? 5 : 3)), 16'(uvSeconds));
      @(posedge clock);
      mainsSag <= 1'b0;
      clr();
      chk("uvFault", 16'h0000, 16'(uvFault));
    end
  endtask : t_uvLimit

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    running <= 1'b1;
    t_defaults();
    t_ref();
    t_phase();
    t_uvEntry();
    t_uvLimit();
    give_verdict();
  end

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
